// ---- pkg/inj_defs.vh ----
/*
 * Constants for the injector current phase control core: channel and
 * group counts, phase codes and reset levels of the synchronised inputs.
 * Assumes inclusion by bare name from the core and verification files.
 */
`ifndef INJ_DEFS_VH
`define INJ_DEFS_VH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define NUM_CH        4
`define NUM_GRP       2
`define PH_W          3
`define SYNC_W        25

// ------------------------------------------------------------
// phase codes
// ------------------------------------------------------------
`define PH_OFF        3'h0
`define PH_PRE        3'h1
`define PH_PEAK       3'h2
`define PH_HOLD       3'h3
`define PH_DAMP       3'h4

// ------------------------------------------------------------
// synchroniser reset levels, packed as in the core
// ------------------------------------------------------------
`define RST_ON_N      4'hF
`define RST_PCH       2'h0
`define RST_TIED      1'h0
`define RST_PIN_N     1'h0
`define RST_UV        1'h1
`define RST_CMP       4'h0

// ------------------------------------------------------------
// output levels
// ------------------------------------------------------------
`define HS_OFF_N      2'h3
`define LS_ALL_OFF    4'h0

`endif

// ---- core/inj_sync2.v ----
/*
 * Two-stage synchroniser for a vector of pin inputs.
 * Assumes a single clock and a synchronous active-high reset; the reset
 * level of each bit is given by RST_VAL.
 */
`timescale 1ns/10ps

module inj_sync2
#(
	parameter       W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
	input  wire         clk_in,
	input  wire         srst_in,
	input  wire [W-1:0] d_in,
	output reg  [W-1:0] q_out
);

	reg [W-1:0] meta_r;

	// ------------------------------------------------------------
	// two flops; the first is read by the second only
	// ------------------------------------------------------------
	always @(posedge clk_in)
	begin
		if (srst_in)
		begin
			meta_r <= RST_VAL;
			q_out  <= RST_VAL;
		end
		else
		begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end

endmodule // inj_sync2

// ---- core/inj_hyst_reg.v ----
/*
 * Hysteresis current regulator for one channel.
 * Assumes comparator levels already synchronised; en is low outside the
 * regulated phases, which forces the drive request off.
 */
`timescale 1ns/10ps

module inj_hyst_reg
(
	input  wire clk_in,
	input  wire srst_in,
	input  wire en_in,
	input  wire below_lower_in,
	input  wire above_upper_in,
	output reg  drive_out
);

	reg drive_nxt;

	// ------------------------------------------------------------
	// on below lower, off above upper, hold in between
	// ------------------------------------------------------------
	always @*
	begin
		drive_nxt = drive_out;
		if (!en_in)
			drive_nxt = 1'b0;
		else if (above_upper_in)
			drive_nxt = 1'b0;
		else if (below_lower_in)
			drive_nxt = 1'b1;
	end

	always @(posedge clk_in)
	begin
		if (srst_in)
			drive_out <= 1'b0;
		else
			drive_out <= drive_nxt;
	end

endmodule // inj_hyst_reg

// ---- core/inj_phase_ctrl.v ----
/*
 * Four-channel injector switch control and current phase sequencer.
 * Channels 0,1 form group A and channels 2,3 group B; each group has one
 * battery high-side control and one boost high-side control, both
 * active low. Assumes comparator, trip and pin inputs are asynchronous
 * and are synchronised here; one 100 MHz clock, synchronous reset.
 */
`timescale 1ns/10ps
`include "inj_defs.vh"

module inj_phase_ctrl
(
	input  wire        REF_CLK_IN,
	input  wire        SRST_IN,
	input  wire [3:0]  CHANNEL_ON_N_IN,
	input  wire [1:0]  PRECHARGE_SEL_IN,
	input  wire        PRECHARGE_PROGRAM_TIED_IN,
	input  wire        RESET_PIN_N_IN,
	input  wire        UNDERVOLTAGE_IN,
	input  wire [3:0]  CUR_BELOW_LOWER_IN,
	input  wire [3:0]  CUR_ABOVE_UPPER_IN,
	input  wire [3:0]  PEAK_REACHED_IN,
	input  wire [3:0]  PROTECT_TRIP_IN,
	output reg  [3:0]  LOW_SIDE_ON_OUT,
	output reg  [1:0]  HIGH_SIDE_A_CTL_N_OUT,
	output reg  [1:0]  HIGH_SIDE_B_CTL_N_OUT,
	output reg  [11:0] CHANNEL_PHASE_OUT,
	output reg  [3:0]  PROTECT_LATCHED_OUT
);

	// ------------------------------------------------------------
	// next phase of one channel
	// ------------------------------------------------------------
	function [`PH_W-1:0] next_phase;
		input [`PH_W-1:0] ph;
		input             on_req;
		input             pch;
		input             pch_rise;
		input             tied;
		input             peak;
		input             fault;
		begin
			next_phase = `PH_OFF;
			if (fault || !on_req)
				next_phase = `PH_OFF;
			else
			begin
				case (ph)
					`PH_OFF:
						if (tied || !pch)
							next_phase = `PH_PEAK;
						else
							next_phase = `PH_PRE;
					`PH_PRE:
						if (tied || !pch)
							next_phase = `PH_PEAK;
						else
							next_phase = `PH_PRE;
					`PH_PEAK:
						if (peak)
							next_phase = `PH_HOLD;
						else
							next_phase = `PH_PEAK;
					`PH_HOLD:
						if (!tied && pch_rise)
							next_phase = `PH_DAMP;
						else
							next_phase = `PH_HOLD;
					`PH_DAMP:
						// a strap change mid-pulse must not leave damp running
						if (tied)
							next_phase = `PH_HOLD;
						else
							next_phase = `PH_DAMP;
					default:
						next_phase = `PH_OFF;
				endcase
			end
		end
	endfunction

	// ------------------------------------------------------------
	// regulated phases
	// ------------------------------------------------------------
	function is_regulated;
		input [`PH_W-1:0] ph;
		begin
			is_regulated = (ph == `PH_PRE) || (ph == `PH_HOLD) ||
				(ph == `PH_DAMP);
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	wire [`SYNC_W-1:0] sync_raw;
	wire [`SYNC_W-1:0] sync_q;

	assign sync_raw = {CHANNEL_ON_N_IN, PRECHARGE_SEL_IN,
		PRECHARGE_PROGRAM_TIED_IN, RESET_PIN_N_IN, UNDERVOLTAGE_IN,
		CUR_BELOW_LOWER_IN, CUR_ABOVE_UPPER_IN, PEAK_REACHED_IN,
		PROTECT_TRIP_IN};

	// open on inputs float high; reset level matches that
	inj_sync2
	#(
		.W       (`SYNC_W),
		.RST_VAL ({`RST_ON_N, `RST_PCH, `RST_TIED, `RST_PIN_N, `RST_UV,
			`RST_CMP, `RST_CMP, `RST_CMP, `RST_CMP})
	)
	u_sync
	(
		.clk_in  (REF_CLK_IN),
		.srst_in (SRST_IN),
		.d_in    (sync_raw),
		.q_out   (sync_q)
	);

	wire [3:0] on_n_s;
	wire [1:0] pch_s;
	wire       tied_s;
	wire       rst_pin_n_s;
	wire       uv_s;
	wire [3:0] below_s;
	wire [3:0] above_s;
	wire [3:0] peak_s;
	wire [3:0] trip_s;

	assign on_n_s      = sync_q[24:21];
	assign pch_s       = sync_q[20:19];
	assign tied_s      = sync_q[18];
	assign rst_pin_n_s = sync_q[17];
	assign uv_s        = sync_q[16];
	assign below_s     = sync_q[15:12];
	assign above_s     = sync_q[11:8];
	assign peak_s      = sync_q[7:4];
	assign trip_s      = sync_q[3:0];

	// ------------------------------------------------------------
	// device reset: clock reset, reset pin or undervoltage
	// ------------------------------------------------------------
	wire dev_rst;

	assign dev_rst = SRST_IN | ~rst_pin_n_s | uv_s;

	// ------------------------------------------------------------
	// pre-charge select edge detect, per group
	// ------------------------------------------------------------
	reg [1:0] pch_d_r;

	always @(posedge REF_CLK_IN)
	begin
		if (dev_rst)
			pch_d_r <= `RST_PCH;
		else
			pch_d_r <= pch_s;
	end

	wire [1:0] pch_rise;

	assign pch_rise = pch_s & ~pch_d_r;

	// ------------------------------------------------------------
	// per-channel sequencer, protection latch and regulator
	// ------------------------------------------------------------
	reg  [`PH_W-1:0] ph_r      [0:`NUM_CH-1];
	reg  [3:0]       fault_r;
	wire [3:0]       fault_nxt;
	wire [3:0]       reg_drive;
	wire [3:0]       in_peak;
	wire [3:0]       ls_nxt;
	wire [11:0]      ph_flat;

	genvar i;
	generate
		for (i = 0; i < `NUM_CH; i = i + 1)
		begin : g_ch
			wire [`PH_W-1:0] ph_nxt;

			// a new trip wins over the clear by a high on input
			assign fault_nxt[i] = trip_s[i] |
				(fault_r[i] & ~on_n_s[i]);

			assign ph_nxt = next_phase(ph_r[i], ~on_n_s[i],
				pch_s[i/2], pch_rise[i/2], tied_s, peak_s[i],
				fault_nxt[i]);

			always @(posedge REF_CLK_IN)
			begin
				if (dev_rst)
				begin
					ph_r[i]    <= `PH_OFF;
					fault_r[i] <= 1'b0;
				end
				else
				begin
					ph_r[i]    <= ph_nxt;
					fault_r[i] <= fault_nxt[i];
				end
			end

			inj_hyst_reg u_reg
			(
				.clk_in         (REF_CLK_IN),
				.srst_in        (dev_rst),
				.en_in          (is_regulated(ph_r[i]) & ~fault_nxt[i]),
				.below_lower_in (below_s[i]),
				.above_upper_in (above_s[i]),
				.drive_out      (reg_drive[i])
			);

			assign in_peak[i] = (ph_r[i] == `PH_PEAK) & ~fault_nxt[i];

			// switch follows its own on input, forced off by its own fault
			assign ls_nxt[i] = ~on_n_s[i] & ~fault_nxt[i];

			assign ph_flat[i*`PH_W +: `PH_W] = ph_r[i];
		end
	endgenerate

	// ------------------------------------------------------------
	// group high-side requests
	// ------------------------------------------------------------
	// one bank drives one load at a time, so an OR per group suffices
	wire [1:0] hs_a_req;
	wire [1:0] hs_b_req;

	assign hs_a_req = {reg_drive[3] | reg_drive[2],
		reg_drive[1] | reg_drive[0]};
	assign hs_b_req = {in_peak[3] | in_peak[2], in_peak[1] | in_peak[0]};

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	// switch follows on input each cycle, off while its fault is set; device reset loads all switches off
	always @(posedge REF_CLK_IN)
	begin
		if (dev_rst)
		begin
			LOW_SIDE_ON_OUT       <= `LS_ALL_OFF;
			HIGH_SIDE_A_CTL_N_OUT <= `HS_OFF_N;
			HIGH_SIDE_B_CTL_N_OUT <= `HS_OFF_N;
			CHANNEL_PHASE_OUT     <= {`NUM_CH{`PH_OFF}};
			PROTECT_LATCHED_OUT   <= `LS_ALL_OFF;
		end
		else
		begin
			LOW_SIDE_ON_OUT       <= ls_nxt;
			HIGH_SIDE_A_CTL_N_OUT <= ~hs_a_req;
			HIGH_SIDE_B_CTL_N_OUT <= ~hs_b_req;
			CHANNEL_PHASE_OUT     <= ph_flat;
			PROTECT_LATCHED_OUT   <= fault_r;
		end
	end

endmodule // inj_phase_ctrl

// ---- verif/inj_phase_ctrl_asserts.sv ----
/* checker of the phase control outputs
   assumes the ports of inj_phase_ctrl, one clock */
`timescale 1ns/10ps
`include "inj_defs.vh"

module inj_phase_ctrl_asserts
(
	input wire        REF_CLK_IN,
	input wire        SRST_IN,
	input wire [3:0]  CHANNEL_ON_N_IN,
	input wire [1:0]  PRECHARGE_SEL_IN,
	input wire        PRECHARGE_PROGRAM_TIED_IN,
	input wire        RESET_PIN_N_IN,
	input wire        UNDERVOLTAGE_IN,
	input wire [3:0]  CUR_BELOW_LOWER_IN,
	input wire [3:0]  CUR_ABOVE_UPPER_IN,
	input wire [3:0]  PEAK_REACHED_IN,
	input wire [3:0]  PROTECT_TRIP_IN,
	input wire [3:0]  LOW_SIDE_ON_OUT,
	input wire [1:0]  HIGH_SIDE_A_CTL_N_OUT,
	input wire [1:0]  HIGH_SIDE_B_CTL_N_OUT,
	input wire [11:0] CHANNEL_PHASE_OUT,
	input wire [3:0]  PROTECT_LATCHED_OUT
);
	wire [11:0] p;
	wire [3:0]  act;
	genvar      g;

	assign p = CHANNEL_PHASE_OUT;
	assign act = {|p[11:9], |p[8:6], |p[5:3], |p[2:0]};

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SRST_IN);

	// ----
	// sequences
	// ----
	// windows longer than the worst sync plus register lag
	sequence s_pin_low; (!RESET_PIN_N_IN)[*5]; endsequence
	sequence s_uv; UNDERVOLTAGE_IN[*5]; endsequence
	sequence s_a_idle; (&CHANNEL_ON_N_IN[1:0])[*8]; endsequence
	sequence s_a_above; (&CUR_ABOVE_UPPER_IN[1:0])[*6]; endsequence
	// phase output trails the switch by one edge outside device reset
	sequence s_run; (RESET_PIN_N_IN && !UNDERVOLTAGE_IN)[*4]; endsequence

	AST_PIN: assert property (s_pin_low |-> LOW_SIDE_ON_OUT == 4'h0
		&& HIGH_SIDE_A_CTL_N_OUT == 2'h3 && HIGH_SIDE_B_CTL_N_OUT == 2'h3)
		else $error("pin reset left a switch on");
	AST_UV: assert property (s_uv |-> LOW_SIDE_ON_OUT == 4'h0
		&& HIGH_SIDE_A_CTL_N_OUT == 2'h3 && HIGH_SIDE_B_CTL_N_OUT == 2'h3)
		else $error("undervoltage left a switch on");
	AST_ACT: assert property (s_run |-> act == $past(LOW_SIDE_ON_OUT))
		else $error("switch and phase disagree");
	AST_IDLE: assert property (s_a_idle |-> HIGH_SIDE_A_CTL_N_OUT[0]
		&& HIGH_SIDE_B_CTL_N_OUT[0])
		else $error("high side on with group idle");
	AST_ABOVE: assert property (s_a_above |-> HIGH_SIDE_A_CTL_N_OUT[0])
		else $error("battery side on above upper level");
	AST_BOOST: assert property (!HIGH_SIDE_B_CTL_N_OUT[0] |->
		(p[2:0] == `PH_PEAK || p[5:3] == `PH_PEAK))
		else $error("boost side on outside peak");

	generate for (g = 0; g < 4; g = g + 1)
	begin : ch
		AST_OFF: assert property (CHANNEL_ON_N_IN[g][*5] |->
			!LOW_SIDE_ON_OUT[g])
			else $error("switch on without request");
		AST_TIED: assert property (PRECHARGE_PROGRAM_TIED_IN[*8] |->
			p[3*g+:3] != `PH_PRE && p[3*g+:3] != `PH_DAMP)
			else $error("pre-charge or damp while tied");
		AST_FLT: assert property (PROTECT_LATCHED_OUT[g][*2] |->
			!LOW_SIDE_ON_OUT[g])
			else $error("switch on with latched fault");
		AST_CLR: assert property ((CHANNEL_ON_N_IN[g]
			&& !PROTECT_TRIP_IN[g])[*6] |-> !PROTECT_LATCHED_OUT[g])
			else $error("fault latch not cleared");
	end
	endgenerate
endmodule // inj_phase_ctrl_asserts

bind inj_phase_ctrl inj_phase_ctrl_asserts chk_u (.REF_CLK_IN, .SRST_IN,
	.CHANNEL_ON_N_IN, .PRECHARGE_SEL_IN, .PRECHARGE_PROGRAM_TIED_IN,
	.RESET_PIN_N_IN, .UNDERVOLTAGE_IN, .CUR_BELOW_LOWER_IN,
	.CUR_ABOVE_UPPER_IN, .PEAK_REACHED_IN, .PROTECT_TRIP_IN,
	.LOW_SIDE_ON_OUT, .HIGH_SIDE_A_CTL_N_OUT, .HIGH_SIDE_B_CTL_N_OUT,
	.CHANNEL_PHASE_OUT, .PROTECT_LATCHED_OUT);

// ---- verif/inj_ctl_model.sv ----
/* controller model driving the on inputs
   assumes load requests from the bench, one clock */
`timescale 1ns/10ps

module inj_ctl_model
(
	input  wire       clk_in,
	input  wire [3:0] req_in,
	output reg  [3:0] on_n_out
);
	initial on_n_out = 4'hF;
	// one load per bank, lower channel wins a clash
	always @(posedge clk_in)
	begin
		on_n_out[0] <= !req_in[0];
		on_n_out[1] <= !(req_in[1] && !req_in[0]);
		on_n_out[2] <= !req_in[2];
		on_n_out[3] <= !(req_in[3] && !req_in[2]);
	end
endmodule // inj_ctl_model

// ---- verif/inj_phase_ctrl_tb.sv ----
/* self-checking bench of the phase control core
   assumes the core, its bound checker and the controller model */
`timescale 1ns/10ps
`include "inj_defs.vh"

module inj_phase_ctrl_tb;
	reg         clk, srst, tied, rpn, uv;
	reg  [3:0]  req, blw, abv, pk, trip, r;
	reg  [1:0]  sel;
	wire [3:0]  on_n, ls, pl;
	wire [1:0]  hsa, hsb;
	wire [11:0] ph;
	integer     err_count, samples_checked, i;

	inj_ctl_model ctl_u (.clk_in(clk), .req_in(req), .on_n_out(on_n));
	inj_phase_ctrl dut_u (.REF_CLK_IN(clk), .SRST_IN(srst),
		.CHANNEL_ON_N_IN(on_n), .PRECHARGE_SEL_IN(sel),
		.PRECHARGE_PROGRAM_TIED_IN(tied), .RESET_PIN_N_IN(rpn),
		.UNDERVOLTAGE_IN(uv), .CUR_BELOW_LOWER_IN(blw),
		.CUR_ABOVE_UPPER_IN(abv), .PEAK_REACHED_IN(pk),
		.PROTECT_TRIP_IN(trip), .LOW_SIDE_ON_OUT(ls),
		.HIGH_SIDE_A_CTL_N_OUT(hsa), .HIGH_SIDE_B_CTL_N_OUT(hsb),
		.CHANNEL_PHASE_OUT(ph), .PROTECT_LATCHED_OUT(pl));

	// ----
	// helpers
	// ----
	function [3:0] exp_on(input [3:0] q);
		exp_on = {q[3] & !q[2], q[2], q[1] & !q[0], q[0]};
	endfunction
	task end_of_test;
	begin
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task chk(input [11:0] e, input [11:0] g);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	end
	endtask
	task chk_ls(input [3:0] e);
	begin
		chk({8'h00, e}, {8'h00, ls});
	end
	endtask
	task chk_ph(input integer c, input [2:0] e);
	begin
		chk({9'h000, e}, {9'h000, ph[3*c+:3]});
	end
	endtask
	task chk_hs(input [1:0] e, input [1:0] g);
	begin
		chk({10'h000, e}, {10'h000, g});
	end
	endtask
	task chk_pl(input [3:0] e);
	begin
		chk({8'h00, e}, {8'h00, pl});
	end
	endtask
	// worst lag is 6 edges: model, sync, phase, regulator, output
	task w;
	begin
		repeat (8) @(posedge clk);
		#1;
	end
	endtask

	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#200000;
		err_count = err_count + 1;
		end_of_test;
	end

	// ----
	// tests
	// ----
	initial
	begin
		err_count = 0;
		samples_checked = 0;
		srst = 1;
		tied = 0;
		rpn = 1;
		uv = 0;
		sel = 2'h0;
		req = 4'h2;
		blw = 4'h0;
		abv = 4'h0;
		pk = 4'h0;
		trip = 4'h0;
		r = 4'($urandom(81));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		w;
		chk_ls(4'h2);
		@(posedge clk) req <= 4'h0;
		@(posedge clk);
		sel <= 2'h1;
		req <= 4'h1;
		blw <= 4'h1;
		w;
		chk_ph(0, `PH_PRE);
		chk_hs(2'h2, hsa);
		@(posedge clk);
		abv <= 4'h1;
		blw <= 4'h0;
		w;
		chk_hs(2'h3, hsa);
		@(posedge clk) abv <= 4'h0;
		w;
		chk_hs(2'h3, hsa);
		@(posedge clk) sel <= 2'h0;
		w;
		chk_ph(0, `PH_PEAK);
		chk_hs(2'h2, hsb);
		@(posedge clk);
		pk <= 4'h1;
		blw <= 4'h1;
		w;
		chk_ph(0, `PH_HOLD);
		chk_hs(2'h3, hsb);
		chk_hs(2'h2, hsa);
		@(posedge clk);
		sel <= 2'h1;
		pk <= 4'h0;
		w;
		chk_ph(0, `PH_DAMP);
		@(posedge clk);
		abv <= 4'h1;
		blw <= 4'h0;
		w;
		chk_hs(2'h3, hsa);
		@(posedge clk);
		req <= 4'h0;
		sel <= 2'h0;
		abv <= 4'h0;
		w;
		chk_ls(4'h0);
		chk_ph(0, `PH_OFF);
		// no select edge in hold: stays hold, then off
		@(posedge clk) req <= 4'h1;
		@(posedge clk) pk <= 4'h1;
		w;
		chk_ph(0, `PH_HOLD);
		@(posedge clk);
		req <= 4'h0;
		pk <= 4'h0;
		w;
		chk_ph(0, `PH_OFF);
		@(posedge clk);
		tied <= 1'b1;
		sel <= 2'h2;
		@(posedge clk) req <= 4'h4;
		w;
		chk_ph(2, `PH_PEAK);
		@(posedge clk) pk <= 4'h4;
		@(posedge clk) sel <= 2'h0;
		w;
		chk_ph(2, `PH_HOLD);
		@(posedge clk) sel <= 2'h2;
		w;
		chk_ph(2, `PH_HOLD);
		@(posedge clk);
		req <= 4'h0;
		pk <= 4'h0;
		w;
		@(posedge clk);
		tied <= 1'b0;
		req <= 4'h8;
		@(posedge clk) trip <= 4'h8;
		w;
		chk_ls(4'h0);
		chk_pl(4'h8);
		@(posedge clk) trip <= 4'h0;
		w;
		chk_pl(4'h8);
		@(posedge clk) req <= 4'h0;
		w;
		chk_pl(4'h0);
		@(posedge clk);
		req <= 4'h1;
		blw <= 4'h1;
		@(posedge clk) rpn <= 1'b0;
		w;
		chk_ls(4'h0);
		chk_hs(2'h3, hsa);
		chk_hs(2'h3, hsb);
		@(posedge clk) rpn <= 1'b1;
		w;
		chk_ls(4'h1);
		@(posedge clk) uv <= 1'b1;
		w;
		chk_ls(4'h0);
		chk_hs(2'h3, hsa);
		chk_hs(2'h3, hsb);
		@(posedge clk);
		uv <= 1'b0;
		req <= 4'h0;
		for (i = 0; i < 200; i = i + 1)
		begin
			@(posedge clk);
			r = 4'($urandom);
			req <= r;
			sel <= 2'($urandom);
			blw <= 4'($urandom);
			abv <= 4'($urandom);
			pk <= 4'($urandom);
			w;
			chk_ls(exp_on(r));
		end
		end_of_test;
	end
endmodule // inj_phase_ctrl_tb
